/* File: core/bus_phase_consts.svh */
`ifndef BUS_PHASE_CONSTS_SVH
`define BUS_PHASE_CONSTS_SVH
// ==========================================================
// bus widths
`define ADDR_W 32
`define DATA_W 32
`define SIZE_W 2
`define TYPE_W 2
`define IPL_W 3
// ==========================================================
// phase counter encodings, one code per bus phase state
`define PHASE_T1 2'h0
`define PHASE_T2 2'h1
`define PHASE_T3 2'h2
`define PHASE_T4 2'h3
// phase advance per core cycle: two states per core clock
`define PHASE_STEP 2'h2
// ==========================================================
// reset values
`define ADDR_RST 32'h0000_0000
`define DATA_RST 32'h0000_0000
`define IPL_RST 3'h0
// synchroniser width: bus clock, ack, ipl, reset, data
`define SYNC_W 38
`endif

/* File: core/bus_phase_pkg.sv */
package bus_phase_pkg;
   // ==========================================================
   // request from the core side
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic write;
      logic [1:0] size;
      logic [1:0] ttype;
   } bus_req_s;
   // ==========================================================
   // bus cycle sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DATA,
      ST_END,
      ST_RELEASE
   } bus_state_e;
endpackage : bus_phase_pkg

/* File: core/bus_phase_timing.sv */
// Summary of operation
// - drive 32-bit address and data buses
// - drive start, type, write, size controls
// - core clock runs twice bus clock
// - bus outputs timed from bus phases only
// - bus clock rising edge is reference
// - two core cycles form states T1-T4
// - most outputs change in T4
// - tip/busy levels T4, release T1; ack never driven
// - other inputs sampled at bus clock rise
// - ipl and reset input synchronised first
`timescale 1ns/1ps
`default_nettype none
`include "bus_phase_consts.svh"
module bus_phase_timing
   import bus_phase_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic bclk_in,
   input wire bus_req_s req_in,
   input wire logic req_valid_in,
   output logic req_ready_out,
   output logic rsp_valid_out,
   output logic [31:0] rsp_rdata_out,
   output logic [31:0] addr_out,
   output logic addr_oe_n_out,
   output logic [31:0] data_out,
   output logic data_oe_n_out,
   input wire logic [31:0] data_in,
   output logic start_n_out,
   output logic write_out,
   output logic [1:0] size_out,
   output logic [1:0] ttype_out,
   output logic transfer_in_progress_n_out,
   output logic transfer_in_progress_oe_n_out,
   output logic transfer_acknowledge_n_out,
   output logic transfer_acknowledge_oe_n_out,
   input wire logic transfer_acknowledge_n_in,
   output logic bus_busy_n_out,
   output logic bus_busy_oe_n_out,
   input wire logic [2:0] interrupt_priority_level_n_in,
   input wire logic reset_input_n_in,
   output logic [2:0] ipl_level_out,
   output logic reset_req_out
);

   // ==========================================================
   // input synchronisers
   logic [`SYNC_W-1:0] sync1_q;
   logic [`SYNC_W-1:0] sync2_q;
   logic [`SYNC_W-1:0] pins;
   logic bclk_prev_q;
   logic bclk_prev2_q;
   logic locked_q;
   logic bclk_rise;
   logic [1:0] phase_q;
   bus_state_e state_q;
   logic start_n_q;
   logic tip_n_q;
   logic tip_oe_n_q;
   logic bb_n_q;
   logic bb_oe_n_q;
   logic [31:0] addr_q;
   logic addr_oe_n_q;
   logic [31:0] wdata_q;
   logic data_oe_n_q;
   logic write_q;
   logic [1:0] size_q;
   logic [1:0] ttype_q;
   logic ready_q;
   logic rsp_valid_q;
   logic [31:0] rdata_q;
   logic [2:0] ipl_q;
   logic reset_req_q;
   logic at_t4;
   logic at_t1;
   logic take;

   // phase test used for both output timing points
   function automatic logic in_phase(input logic [1:0] ph, input logic [1:0] want);
      in_phase = (ph == want);
   endfunction : in_phase

   // every pin input joins one vector for the flop pair
   assign pins = {bclk_in, transfer_acknowledge_n_in, interrupt_priority_level_n_in,
                  reset_input_n_in, data_in};

   genvar gi;
   generate
      for (gi = 0; gi < `SYNC_W; gi++) begin : g_sync
         // two flops per pin before any logic reads it
         always_ff @(posedge core_clk_in) begin
            if (rst_in) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else if (ce_in) begin
               sync1_q[gi] <= pins[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   // ==========================================================
   // bus clock edge detect and phase counter
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         bclk_prev_q <= 1'b0;
         bclk_prev2_q <= 1'b0;
      end else if (ce_in) begin
         bclk_prev_q <= sync2_q[37];
         bclk_prev2_q <= bclk_prev_q;
      end
   end

   // two history stages give an even detect delay (two bus cycles),
   // so phase T1 falls on the bus clock high half, not the low one
   assign bclk_rise = bclk_prev_q & ~bclk_prev2_q;

   // phase count means nothing until the first bus clock rise is seen
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         locked_q <= 1'b0;
      end else if (ce_in && bclk_rise) begin
         locked_q <= 1'b1;
      end
   end

   // two core cycles per bus cycle, two states each
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         phase_q <= `PHASE_T1;
      end else if (ce_in) begin
         if (bclk_rise) begin
            phase_q <= `PHASE_T1;
         end else begin
            phase_q <= phase_q + `PHASE_STEP;
         end
      end
   end

   // next edge enters T3-T4, or the next bus clock rise (T1)
   assign at_t4 = ce_in & locked_q & in_phase(phase_q, `PHASE_T1) & ~bclk_rise;
   assign at_t1 = ce_in & locked_q & in_phase(phase_q, `PHASE_T3);
   assign take = at_t4 & req_valid_in & ~ready_q & (state_q == ST_IDLE);

   // ==========================================================
   // bus cycle sequencer
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take) begin
                  state_q <= ST_DATA;
               end
            end
            ST_DATA: begin
               if (at_t1 && !sync2_q[36]) begin
                  state_q <= ST_END;
               end
            end
            ST_END: begin
               if (at_t4) begin
                  state_q <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               if (at_t1) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // address, data and control outputs, changed only at T4
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         addr_q <= `ADDR_RST;
         wdata_q <= `DATA_RST;
         addr_oe_n_q <= 1'b1;
         data_oe_n_q <= 1'b1;
         write_q <= 1'b0;
         size_q <= 2'h0;
         ttype_q <= 2'h0;
      end else if (take) begin
         addr_q <= req_in.addr;
         wdata_q <= req_in.wdata;
         addr_oe_n_q <= 1'b0;
         data_oe_n_q <= ~req_in.write;
         write_q <= req_in.write;
         size_q <= req_in.size;
         ttype_q <= req_in.ttype;
      end else if (at_t4 && state_q == ST_END) begin
         addr_oe_n_q <= 1'b1;
         data_oe_n_q <= 1'b1;
      end
   end

   // start strobe lasts one bus cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         start_n_q <= 1'b1;
      end else if (take) begin
         start_n_q <= 1'b0;
      end else if (at_t4) begin
         start_n_q <= 1'b1;
      end
   end

   // tip and busy: levels at T4, release at T1
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         tip_n_q <= 1'b1;
         tip_oe_n_q <= 1'b1;
         bb_n_q <= 1'b1;
         bb_oe_n_q <= 1'b1;
      end else if (take) begin
         tip_n_q <= 1'b0;
         tip_oe_n_q <= 1'b0;
         bb_n_q <= 1'b0;
         bb_oe_n_q <= 1'b0;
      end else if (at_t4 && state_q == ST_END) begin
         tip_n_q <= 1'b1;
         bb_n_q <= 1'b1;
      end else if (at_t1 && state_q == ST_RELEASE) begin
         tip_oe_n_q <= 1'b1;
         bb_oe_n_q <= 1'b1;
      end
   end

   // request accept and read response
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rdata_q <= `DATA_RST;
      end else if (ce_in) begin
         ready_q <= take;
         rsp_valid_q <= 1'b0;
         if (state_q == ST_DATA && at_t1 && !sync2_q[36]) begin
            rsp_valid_q <= 1'b1;
            rdata_q <= sync2_q[31:0];
         end
      end
   end

   // ==========================================================
   // interrupt level and reset input, taken at bus clock rise
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         ipl_q <= `IPL_RST;
         reset_req_q <= 1'b0;
      end else if (ce_in && bclk_rise) begin
         ipl_q <= ~sync2_q[35:33];
         reset_req_q <= ~sync2_q[32];
      end
   end

   // ==========================================================
   // outputs, all from flops except the constant acknowledge pair
   assign req_ready_out = ready_q;
   assign rsp_valid_out = rsp_valid_q;
   assign rsp_rdata_out = rdata_q;
   assign addr_out = addr_q;
   assign addr_oe_n_out = addr_oe_n_q;
   assign data_out = wdata_q;
   assign data_oe_n_out = data_oe_n_q;
   assign start_n_out = start_n_q;
   assign write_out = write_q;
   assign size_out = size_q;
   assign ttype_out = ttype_q;
   assign transfer_in_progress_n_out = tip_n_q;
   assign transfer_in_progress_oe_n_out = tip_oe_n_q;
   assign transfer_acknowledge_n_out = 1'b1; // acknowledge never driven as master
   assign transfer_acknowledge_oe_n_out = 1'b1;
   assign bus_busy_n_out = bb_n_q;
   assign bus_busy_oe_n_out = bb_oe_n_q;
   assign ipl_level_out = ipl_q;
   assign reset_req_out = reset_req_q;

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in || !ce_in);

   a_phase_wrap: assert property (bclk_rise |=> phase_q == `PHASE_T1)
      else $error("phase not back to T1 after bus clock rise");
   a_phase_step: assert property (!bclk_rise && phase_q == `PHASE_T1 |=> phase_q == `PHASE_T3)
      else $error("phase did not step from T1 to T3");
   a_tip_level: assert property ($changed(tip_n_q) |-> $past(phase_q) == `PHASE_T1)
      else $error("tip level changed outside T4");
   a_tip_release: assert property ($rose(tip_oe_n_q) |-> $past(phase_q) == `PHASE_T3)
      else $error("tip released outside T1");
   a_bb_release: assert property ($rose(bb_oe_n_q) |-> $past(phase_q) == `PHASE_T3 && tip_oe_n_q)
      else $error("busy released outside T1 or apart from tip");
   a_addr_t4: assert property ($changed(addr_q) || $changed(addr_oe_n_q) |-> $past(phase_q) == `PHASE_T1)
      else $error("address changed outside T4");
   a_start_width: assert property ($fell(start_n_q) |=> !start_n_q ##1 start_n_q)
      else $error("start strobe not one bus cycle wide");
   a_ipl_sample: assert property ($changed(ipl_q) |-> $past(bclk_rise))
      else $error("ipl changed away from bus clock rise");
   a_ack_sample: assert property (rsp_valid_q |-> $past(state_q) == ST_DATA && $past(phase_q) == `PHASE_T3)
      else $error("response not tied to acknowledge sample at T1");

   c_write_cycle: cover property (take && req_in.write ##[1:40] state_q == ST_IDLE);
   c_read_cycle: cover property (rsp_valid_q && !write_q);
   c_ipl_change: cover property ($changed(ipl_q));
   c_reset_req: cover property ($rose(reset_req_q));

endmodule : bus_phase_timing
`default_nettype wire

/* File: verification/bus_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_slave_model (
   input wire logic bclk_in,
   input wire logic start_n_in,
   input wire logic write_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wait_in,
   output logic ack_n_out,
   output logic [31:0] rdata_out,
   output logic [31:0] wdata_seen_out
);
   logic pend;
   logic [3:0] cnt;
   logic [31:0] a;
   initial begin
      pend = 1'b0;
      cnt = 4'h0;
      a = 32'h0;
      ack_n_out = 1'b1;
      rdata_out = 32'h0;
      wdata_seen_out = 32'h0;
   end
   // ==========================================================
   // sample the master only at the bus clock rise
   always @(posedge bclk_in) begin
      if (!ack_n_out && write_in) wdata_seen_out <= wdata_in;
      if (!start_n_in) begin
         pend <= 1'b1;
         cnt <= wait_in;
         a <= addr_in;
      end else if (pend && cnt != 4'h0) cnt <= cnt - 4'h1;
   end
   // ==========================================================
   // end the cycle after the chosen wait; drive mid period
   always @(negedge bclk_in) begin
      if (pend && cnt == 4'h0) begin
         ack_n_out <= 1'b0;
         rdata_out <= a ^ 32'h5a5a_a5a5;
         pend <= 1'b0;
      end else begin
         ack_n_out <= 1'b1;
         rdata_out <= ~rdata_out; // released bus inverts its last data every bus cycle
      end
   end
endmodule : bus_slave_model
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   import bus_phase_pkg::*;
   logic core_clk = 1'b0, rst = 1'b1, bclk = 1'b0, req_valid = 1'b0, ack_n, reset_input_n = 1'b1, ce = 1'b1;
   bus_req_s req = '0;
   logic [2:0] ipl_n = 3'h7, ipl_lvl;
   logic [3:0] wait_c = 4'h0;
   logic [31:0] rd_bus, wseen, rsp_rdata, addr, dat;
   logic ready, rsp_valid, addr_oe_n, data_oe_n, start_n, wr, tip_n, tip_oe_n, bb_n, bb_oe_n;
   logic ta_oe_n, rst_req, s_prev, t_prev, o_prev;
   logic [1:0] size, ttype;
   int errors = 0, n_compared = 0, l0, l3;
   // ==========================================================
   // core clock, bus clock at half rate with aligned rises
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) bclk <= ~bclk;
   bus_phase_timing i_dut (.core_clk_in(core_clk), .rst_in(rst), .ce_in(ce), .bclk_in(bclk),
      .req_in(req), .req_valid_in(req_valid), .req_ready_out(ready), .rsp_valid_out(rsp_valid),
      .rsp_rdata_out(rsp_rdata), .addr_out(addr), .addr_oe_n_out(addr_oe_n), .data_out(dat),
      .data_oe_n_out(data_oe_n), .data_in(rd_bus), .start_n_out(start_n), .write_out(wr),
      .size_out(size), .ttype_out(ttype), .transfer_in_progress_n_out(tip_n),
      .transfer_in_progress_oe_n_out(tip_oe_n), .transfer_acknowledge_n_out(),
      .transfer_acknowledge_oe_n_out(ta_oe_n), .transfer_acknowledge_n_in(ack_n),
      .bus_busy_n_out(bb_n), .bus_busy_oe_n_out(bb_oe_n), .interrupt_priority_level_n_in(ipl_n),
      .reset_input_n_in(reset_input_n), .ipl_level_out(ipl_lvl), .reset_req_out(rst_req));
   bus_slave_model i_slave (.bclk_in(bclk), .start_n_in(start_n), .write_in(wr), .addr_in(addr),
      .wdata_in(dat), .wait_in(wait_c), .ack_n_out(ack_n), .rdata_out(rd_bus),
      .wdata_seen_out(wseen));
   // ==========================================================
   // output edges must fall in the right half of the bus period
   always @(posedge core_clk) begin
      #1;
      if (!rst && start_n !== s_prev) `CHK(bclk, 1'b0)
      if (!rst && tip_n !== t_prev) `CHK(bclk, 1'b0)
      if (!rst && tip_oe_n === 1'b1 && o_prev === 1'b0) `CHK(bclk, 1'b1)
      s_prev = start_n;
      t_prev = tip_n;
      o_prev = tip_oe_n;
   end
   task automatic finish_test;
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test
   // ==========================================================
   // one bus cycle; returns cycles from take to response
   task automatic bus_cycle(input logic w, input logic [31:0] a, input logic [31:0] d,
      input logic [3:0] ws, output int lat);
      int i;
      @(negedge core_clk);
      wait_c = ws;
      req = '{addr: a, wdata: d, write: w, size: 2'h2, ttype: 2'h1};
      req_valid = 1'b1;
      for (i = 0; i < 200 && ready !== 1'b1; i++) @(negedge core_clk);
      `CHK(ready, 1'b1)
      `CHK({addr_oe_n, data_oe_n, start_n, tip_n, bb_n}, {1'b0, ~w, 3'h0})
      @(negedge core_clk);
      req_valid = 1'b0;
      lat = 0;
      while (rsp_valid !== 1'b1 && lat < 200) begin
         @(negedge core_clk);
         lat++;
      end
      `CHK(rsp_valid, 1'b1)
      `CHK(addr, a)
      `CHK(wr, w)
      `CHK({size, ttype}, 4'h9)
      if (w) `CHK(wseen, d)
      else `CHK(rsp_rdata, a ^ 32'h5a5a_a5a5)
      repeat (8) @(negedge core_clk);
      `CHK({addr_oe_n, data_oe_n, tip_oe_n, bb_oe_n, ta_oe_n}, 5'h1f)
   endtask : bus_cycle
   // ==========================================================
   // wait states chosen by the slave stretch the cycle exactly
   task automatic t_wait;
      bus_cycle(1'b0, 32'h0000_1004, 32'h0, 4'h0, l0);
      bus_cycle(1'b0, 32'hffff_fffc, 32'h0, 4'h3, l3);
      `CHK(l3 - l0, 6)
   endtask : t_wait
   // ==========================================================
   // asynchronous level and reset inputs pass a synchroniser
   task automatic t_async;
      @(negedge core_clk);
      ipl_n = 3'h5;
      repeat (12) @(negedge core_clk);
      `CHK(ipl_lvl, 3'h2)
      ipl_n = 3'h0;
      @(negedge core_clk);
      `CHK(ipl_lvl, 3'h2)
      reset_input_n = 1'b0;
      repeat (12) @(negedge core_clk);
      `CHK({ipl_lvl, rst_req}, 4'hf)
      reset_input_n = 1'b1;
      repeat (12) @(negedge core_clk);
      `CHK(rst_req, 1'b0)
      // clock enable low freezes the synchronisers and the level output
      ce = 1'b0;
      ipl_n = 3'h6;
      repeat (12) @(negedge core_clk);
      `CHK(ipl_lvl, 3'h7)
      ce = 1'b1;
      repeat (12) @(negedge core_clk);
      `CHK(ipl_lvl, 3'h1)
   endtask : t_async
   initial begin
      repeat (10) @(negedge core_clk);
      rst = 1'b0;
      `CHK({start_n, addr_oe_n, tip_oe_n, bb_oe_n}, 4'hf)
      bus_cycle(1'b1, 32'ha5c3_0f18, 32'h1234_abcd, 4'h1, l0);
      bus_cycle(1'b1, 32'h0000_0000, 32'hffff_ffff, 4'h0, l0);
      t_wait();
      t_async();
      finish_test();
   end
   initial begin
      #50000;
      errors++;
      finish_test();
   end
endmodule : tb
`default_nettype wire
